//--- hdl/iad_decoder.sv
`timescale 1ns/1ps
// Functional notes
// - Unclaimed PCI memory below 16 Mbytes goes to ISA, firmware space included.
// - Unclaimed forwarded write finishes as 8-bit, six ISA clock cycle.
// - Unclaimed forwarded read returns ISA data lines, 8-bit six clock cycle.
// - ISA or DMA accesses below 512 Kbytes always go upstream.
// - 512-640 Kbytes stays on ISA unless limit register bit 1 is zero.
// - Memory limit from bits 7:3; 1 Mbyte to limit goes upstream.
// - Accesses inside the enabled memory hole, 1 Mbyte to limit, never go to main memory.
// - Limit up to 128 Mbytes confined to ISA.
// - 640K to 896K stays on ISA; optional enable forwards video buffer.
// - 896K-960K upstream only when low firmware off and limit bit 3 set.
// - ISA or DMA never reaches host or PCI I/O space.
// - Config, power, IDE master from PCI; legacy from both; DMA subtractive.
// - Interrupt-controller memory window claimed subtractively, from PCI only.
// - PCI upper firmware block goes to ISA, ROM select always.
// - PCI lower firmware block goes to ISA, ROM select only when enabled.
// - Alias of lower block below 4G forwarded only when low firmware enabled.
// - Extended firmware region forwarded with ROM select only when enabled.
// - ISA upper firmware block stays on ISA with ROM select, even shadowed.
// - ISA lower firmware block on ISA when enabled, else main memory if limit bit 3 set.
// - Write-protect setting blocks forwarded writes across whole 512K firmware space.
// - Disk registers, firmware, peripheral bus, event addresses claimed positively.
module iad_decoder (
  input  wire logic               clk,
  input  wire logic               resetn,
  // Access under decode
  input  wire logic               acc_valid,
  input  wire logic [31:0]        acc_addr,
  input  wire logic               acc_from_isa,
  input  wire logic               acc_is_io,
  input  wire logic               acc_write,
  input  wire logic               pci_claimed,
  // Register decode hits from the function decoders
  input  wire logic               hit_cfg,
  input  wire logic               hit_pm,
  input  wire logic               hit_ide_bm,
  input  wire logic               hit_legacy,
  input  wire logic               hit_dma_regs,
  input  wire logic               hit_disk,
  input  wire logic               hit_pbus,
  input  wire logic               hit_event,
  input  wire logic               hit_intc_win,
  // Configuration
  input  wire logic [7:0]         peripheral_bus_chip_select_control,
  input  wire logic [7:0]         main_memory_limit,
  input  wire logic               disk_decode_en,
  input  wire logic               video_fwd_en,
  input  wire logic               fw_write_protect,
  input  wire logic               hole_en,
  input  wire logic [31:0]        hole_base,
  input  wire logic [31:0]        hole_limit,
  // Default ISA cycle
  input  wire logic               isa_claimed,
  input  wire logic [7:0]         isa_data_pins,
  // Results
  output iad_pkg::iad_route_t     route,
  output logic                    firmware_rom_select_n,
  output logic                    write_blocked,
  output logic                    dflt_busy,
  output logic                    dflt_done,
  output logic [7:0]              dflt_rdata
);
  typedef struct packed {
    logic [7:0] pin1_ff;
    logic [7:0] pin2_ff;
    logic [7:0] rdata_ff;
  } iad_dec_t;
  iad_dec_t s_ff;
  iad_dec_t nxt_s;

  logic        low_fw_en;
  logic        ext_fw_en;
  logic [31:0] mem_top;
  logic        in_low, in_dos, in_vga, in_rom_gap, in_fw_lo, in_fw_hi;
  logic        in_ext, in_isa16, in_alias_lo, in_alias_hi, in_hole;
  logic        in_upper_ram, in_isa_space;
  logic        fw_space;
  logic        dflt_start;
  iad_pkg::iad_route_t nxt_route;
  logic        rom_sel;

  assign low_fw_en = peripheral_bus_chip_select_control[iad_pkg::PBCS_LOW_FW_EN];
  assign ext_fw_en = peripheral_bus_chip_select_control[iad_pkg::PBCS_EXT_FW_EN];
  // Limit in Mbytes is field value plus one
  assign mem_top = 32'({27'h0, main_memory_limit[7:iad_pkg::MML_LIMIT_LSB]} + 32'h1)
                   << iad_pkg::MML_STEP_SHIFT;

  // Address window compares
  iad_range u_low   (.addr(acc_addr), .base(32'h0), .limit(iad_pkg::LOW_DOS_TOP),
                     .hit(in_low));
  iad_range u_dos   (.addr(acc_addr), .base(iad_pkg::LOW_DOS_TOP),
                     .limit(iad_pkg::DOS_TOP), .hit(in_dos));
  iad_range u_vga   (.addr(acc_addr), .base(iad_pkg::DOS_TOP),
                     .limit(iad_pkg::VGA_TOP), .hit(in_vga));
  iad_range u_gap   (.addr(acc_addr), .base(iad_pkg::VGA_TOP),
                     .limit(iad_pkg::FW_LO_BASE), .hit(in_rom_gap));
  iad_range u_fwlo  (.addr(acc_addr), .base(iad_pkg::FW_LO_BASE),
                     .limit(iad_pkg::FW_HI_BASE), .hit(in_fw_lo));
  iad_range u_fwhi  (.addr(acc_addr), .base(iad_pkg::FW_HI_BASE),
                     .limit(iad_pkg::ONE_MEG), .hit(in_fw_hi));
  iad_range u_uram  (.addr(acc_addr), .base(iad_pkg::ONE_MEG), .limit(mem_top),
                     .hit(in_upper_ram));
  iad_range u_isasp (.addr(acc_addr), .base(mem_top),
                     .limit(iad_pkg::ISA_SPACE_TOP), .hit(in_isa_space));
  iad_range u_isa16 (.addr(acc_addr), .base(32'h0), .limit(iad_pkg::ISA_MEM_TOP),
                     .hit(in_isa16));
  iad_range u_ext   (.addr(acc_addr), .base(iad_pkg::FW_EXT_BASE),
                     .limit(iad_pkg::FW_ALIAS_LO), .hit(in_ext));
  iad_range u_alo   (.addr(acc_addr), .base(iad_pkg::FW_ALIAS_LO),
                     .limit(iad_pkg::FW_ALIAS_HI), .hit(in_alias_lo));
  iad_range u_hole  (.addr(acc_addr), .base(hole_base), .limit(hole_limit),
                     .hit(in_hole));
  assign in_alias_hi = (acc_addr >= iad_pkg::FW_ALIAS_HI);

  // Whole 512K firmware space, both aliases and the low copies
  assign fw_space = in_ext | in_alias_lo | in_alias_hi | in_fw_lo | in_fw_hi;

  // Routing decision, one result per access
  always_comb begin
    nxt_route = iad_pkg::IAD_ROUTE_NONE;
    rom_sel   = 1'b0;
    if (acc_valid) begin
      if (!acc_from_isa) begin
        if (acc_is_io) begin
          if (hit_cfg || hit_pm || hit_ide_bm || hit_legacy) begin
            nxt_route = iad_pkg::IAD_ROUTE_INTERNAL;
          end else if (hit_disk && disk_decode_en) begin
            nxt_route = iad_pkg::IAD_ROUTE_INTERNAL;
          end else if (hit_pbus || hit_event) begin
            nxt_route = iad_pkg::IAD_ROUTE_INTERNAL;
          end else if (hit_dma_regs && !pci_claimed) begin
            nxt_route = iad_pkg::IAD_ROUTE_INTERNAL;
          end
        end else if (hit_intc_win) begin
          if (!pci_claimed) begin
            nxt_route = iad_pkg::IAD_ROUTE_INTERNAL;
          end
        end else if (in_fw_hi) begin
          nxt_route = iad_pkg::IAD_ROUTE_ISA;
          rom_sel   = 1'b1;
        end else if (in_fw_lo) begin
          nxt_route = iad_pkg::IAD_ROUTE_ISA;
          rom_sel   = low_fw_en;
        end else if (in_alias_hi) begin
          nxt_route = iad_pkg::IAD_ROUTE_ISA;
          rom_sel   = 1'b1;
        end else if (in_alias_lo) begin
          if (low_fw_en) begin
            nxt_route = iad_pkg::IAD_ROUTE_ISA;
            rom_sel   = 1'b1;
          end
        end else if (in_ext) begin
          if (ext_fw_en) begin
            nxt_route = iad_pkg::IAD_ROUTE_ISA;
            rom_sel   = 1'b1;
          end
        end else if (in_isa16 && !pci_claimed) begin
          nxt_route = iad_pkg::IAD_ROUTE_ISA;
        end
      end else if (acc_is_io) begin
        // ISA side I/O reaches only the legacy registers
        if (hit_legacy) begin
          nxt_route = iad_pkg::IAD_ROUTE_INTERNAL;
        end else begin
          nxt_route = iad_pkg::IAD_ROUTE_ISA;
        end
      end else begin
        nxt_route = iad_pkg::IAD_ROUTE_ISA;
        if (in_low) begin
          nxt_route = iad_pkg::IAD_ROUTE_UPSTREAM;
        end else if (in_dos) begin
          if (!main_memory_limit[iad_pkg::MML_DOS_HOLE]) begin
            nxt_route = iad_pkg::IAD_ROUTE_UPSTREAM;
          end
        end else if (in_vga) begin
          if (video_fwd_en) begin
            nxt_route = iad_pkg::IAD_ROUTE_UPSTREAM;
          end
        end else if (in_rom_gap) begin
          nxt_route = iad_pkg::IAD_ROUTE_ISA;
        end else if (in_fw_lo) begin
          rom_sel = low_fw_en;
          // Disabled block reaches memory only with the limit forward bit set
          if (!low_fw_en && main_memory_limit[iad_pkg::MML_FW_LO_FWD]) begin
            nxt_route = iad_pkg::IAD_ROUTE_UPSTREAM;
          end
        end else if (in_fw_hi) begin
          rom_sel = 1'b1;
        end else if (in_upper_ram) begin
          if (!(hole_en && in_hole)) begin
            nxt_route = iad_pkg::IAD_ROUTE_UPSTREAM;
          end
        end else if (in_isa_space) begin
          nxt_route = iad_pkg::IAD_ROUTE_ISA;
        end
      end
    end
  end

  assign route                 = nxt_route;
  assign firmware_rom_select_n = ~rom_sel;
  assign write_blocked         = acc_valid && !acc_is_io && acc_write && fw_write_protect
                                 && fw_space && (nxt_route == iad_pkg::IAD_ROUTE_ISA
                                 || nxt_route == iad_pkg::IAD_ROUTE_UPSTREAM);

  // Default cycle when no ISA slave answers a forwarded access
  assign dflt_start = acc_valid && !acc_from_isa && !isa_claimed
                      && (nxt_route == iad_pkg::IAD_ROUTE_ISA);

  iad_isa_timer u_tmr (
    .clk    (clk),
    .resetn (resetn),
    .start  (dflt_start),
    .busy   (dflt_busy),
    .done   (dflt_done)
  );

  // Synchronise ISA data pins, capture at end of the default read
  always_comb begin
    nxt_s         = s_ff;
    nxt_s.pin1_ff = isa_data_pins;
    nxt_s.pin2_ff = s_ff.pin1_ff;
    if (dflt_busy) begin
      nxt_s.rdata_ff = s_ff.pin2_ff;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dflt_rdata = s_ff.rdata_ff;

  // Checks
  chk_low_upstream: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_from_isa && !acc_is_io && acc_addr < iad_pkg::LOW_DOS_TOP)
      |-> route == iad_pkg::IAD_ROUTE_UPSTREAM)
    else $error("low memory not forwarded upstream");
  chk_isa_no_io: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_from_isa && acc_is_io) |-> route != iad_pkg::IAD_ROUTE_UPSTREAM)
    else $error("isa io forwarded upstream");
  chk_fw_hi_sel: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_is_io && in_fw_hi && !hit_intc_win) |-> !firmware_rom_select_n)
    else $error("upper firmware select missing");
  chk_alias_gate: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_from_isa && !acc_is_io && !hit_intc_win && in_alias_lo && !low_fw_en)
      |-> (route == iad_pkg::IAD_ROUTE_NONE && firmware_rom_select_n))
    else $error("disabled alias claimed");
  chk_ext_gate: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_from_isa && !acc_is_io && !hit_intc_win && in_ext)
      |-> (route == iad_pkg::IAD_ROUTE_ISA) == ext_fw_en)
    else $error("extended firmware gate wrong");
  chk_hole_kept: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_from_isa && !acc_is_io && hole_en && in_hole && in_upper_ram)
      |-> route == iad_pkg::IAD_ROUTE_ISA)
    else $error("hole forwarded to memory");
  chk_dflt_len: assert property (@(posedge clk) disable iff (!resetn)
    $rose(dflt_busy) |-> ##71 dflt_busy ##1 (!dflt_busy && dflt_done))
    else $error("default cycle length wrong");
  chk_wp_block: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_write && !acc_is_io && fw_write_protect && in_fw_hi)
      |-> write_blocked)
    else $error("protected firmware write not blocked");
  // ISA side memory map and legacy I/O checks
  chk_dos_fwd: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_from_isa && !acc_is_io && in_dos)
      |-> (route == iad_pkg::IAD_ROUTE_UPSTREAM) == !main_memory_limit[iad_pkg::MML_DOS_HOLE])
    else $error("dos window forwarding wrong");
  chk_gap_isa: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_from_isa && !acc_is_io && in_rom_gap)
      |-> route == iad_pkg::IAD_ROUTE_ISA)
    else $error("rom gap left the isa bus");
  chk_fw_lo_fwd: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_from_isa && !acc_is_io && in_fw_lo)
      |-> (route == iad_pkg::IAD_ROUTE_UPSTREAM)
          == (!low_fw_en && main_memory_limit[iad_pkg::MML_FW_LO_FWD]))
    else $error("lower firmware forwarding wrong");
  chk_upper_ram: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_from_isa && !acc_is_io && in_upper_ram && !(hole_en && in_hole))
      |-> route == iad_pkg::IAD_ROUTE_UPSTREAM)
    else $error("main memory not forwarded");
  chk_isa_space: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_from_isa && !acc_is_io && in_isa_space)
      |-> route == iad_pkg::IAD_ROUTE_ISA)
    else $error("space above limit left the isa bus");
  chk_legacy_isa: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_from_isa && acc_is_io && hit_legacy)
      |-> route == iad_pkg::IAD_ROUTE_INTERNAL)
    else $error("legacy register not claimed from isa");
  // PCI side and idle checks
  chk_pci_subtr: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_from_isa && !acc_is_io && !hit_intc_win && in_isa16 && !in_fw_lo
     && !in_fw_hi) |-> (route == iad_pkg::IAD_ROUTE_ISA) == !pci_claimed)
    else $error("subtractive isa forward wrong");
  chk_idle_none: assert property (@(posedge clk) disable iff (!resetn)
    !acc_valid |-> (route == iad_pkg::IAD_ROUTE_NONE && firmware_rom_select_n
                    && !write_blocked))
    else $error("result without an access");
endmodule

//--- hdl/iad_pkg.sv
package iad_pkg;
  // Address boundaries, byte addresses
  localparam logic [31:0] ISA_MEM_TOP     = 32'h0100_0000; // 16 Mbytes
  localparam logic [31:0] LOW_DOS_TOP     = 32'h0008_0000; // 512 Kbytes
  localparam logic [31:0] DOS_TOP         = 32'h000a_0000; // 640 Kbytes
  localparam logic [31:0] VGA_TOP         = 32'h000c_0000; // 768 Kbytes
  localparam logic [31:0] FW_LO_BASE      = 32'h000e_0000;
  localparam logic [31:0] FW_HI_BASE      = 32'h000f_0000;
  localparam logic [31:0] ONE_MEG         = 32'h0010_0000;
  localparam logic [31:0] ISA_SPACE_TOP   = 32'h0800_0000; // 128 Mbytes
  localparam logic [31:0] FW_EXT_BASE     = 32'hfff8_0000;
  localparam logic [31:0] FW_ALIAS_LO     = 32'hfffe_0000;
  localparam logic [31:0] FW_ALIAS_HI     = 32'hffff_0000;
  // Peripheral bus chip select control fields
  localparam int          PBCS_LOW_FW_EN  = 6;
  localparam int          PBCS_EXT_FW_EN  = 7;
  localparam logic [7:0]  PBCS_RESET      = 8'h03;
  // Main memory limit fields
  localparam int          MML_LIMIT_LSB   = 3;
  localparam int          MML_DOS_HOLE    = 1;
  localparam int          MML_FW_LO_FWD   = 3;
  localparam logic [7:0]  MML_RESET       = 8'h02;
  localparam int          MML_STEP_SHIFT  = 20;   // 1 Mbyte per count of bits [7:3]
  // Unclaimed-target ISA cycle
  localparam int          ISA_DEFAULT_CLKS = 6;
  localparam int          ISA_DIV          = 12;  // PCI clocks per ISA bus clock
  // Routing results
  typedef enum logic [1:0] {
    IAD_ROUTE_NONE     = 2'b00,
    IAD_ROUTE_INTERNAL = 2'b01,
    IAD_ROUTE_ISA      = 2'b10,
    IAD_ROUTE_UPSTREAM = 2'b11
  } iad_route_t;
endpackage

//--- hdl/iad_range.sv
`timescale 1ns/1ps
// Half-open address range compare
module iad_range (
  input  wire logic [31:0] addr,
  input  wire logic [31:0] base,
  input  wire logic [31:0] limit,
  output logic             hit
);
  assign hit = (addr >= base) && (addr < limit);
endmodule

//--- hdl/iad_isa_timer.sv
`timescale 1ns/1ps
// Times a default 8-bit ISA cycle of a fixed count of ISA clocks
module iad_isa_timer #(
  parameter int DIV  = iad_pkg::ISA_DIV,
  parameter int CLKS = iad_pkg::ISA_DEFAULT_CLKS
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  typedef struct packed {
    logic [7:0] div_ff;
    logic [3:0] cnt_ff;
    logic       busy_ff;
    logic       done_ff;
  } iad_tmr_t;
  iad_tmr_t s_ff;
  iad_tmr_t nxt_s;
  logic     isa_tick;

  // One-cycle ISA clock enable
  assign isa_tick = (s_ff.div_ff == 8'(DIV - 1));

  always_comb begin
    nxt_s         = s_ff;
    nxt_s.done_ff = 1'b0;
    nxt_s.div_ff  = isa_tick ? 8'h00 : s_ff.div_ff + 8'h01;
    if (!s_ff.busy_ff) begin
      if (start) begin
        nxt_s.busy_ff = 1'b1;
        nxt_s.cnt_ff  = 4'h0;
        nxt_s.div_ff  = 8'h00;
      end
    end else if (isa_tick) begin
      if (s_ff.cnt_ff == 4'(CLKS - 1)) begin
        nxt_s.busy_ff = 1'b0;
        nxt_s.done_ff = 1'b1;
      end else begin
        nxt_s.cnt_ff = s_ff.cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign busy = s_ff.busy_ff;
  assign done = s_ff.done_ff;
endmodule

//--- tb/iad_isa_bus_model.sv
`timescale 1ns/1ps
// ISA side of the bridge: optional slave plus floating data lines
module iad_isa_bus_model (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                acc_valid,
  input  wire logic                acc_from_isa,
  input  wire iad_pkg::iad_route_t route,
  input  wire logic                dflt_busy,
  input  wire logic                slave_present,
  input  wire logic [7:0]          float_val,
  output logic                     isa_claimed,
  output logic [7:0]               isa_data_pins
);
  // Slave answers at once when present, only for cycles run onto ISA
  assign isa_claimed = slave_present && acc_valid && !acc_from_isa &&
                       (route == iad_pkg::IAD_ROUTE_ISA);
  // Lines hold a residual value in a cycle, wander when idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      isa_data_pins <= 8'h00;
    end else begin
      isa_data_pins <= dflt_busy ? float_val : ~isa_data_pins;
    end
  end
endmodule

//--- tb/test_isa_pci_address_decoder.sv
`timescale 1ns/1ps
module test_isa_pci_address_decoder;
  localparam iad_pkg::iad_route_t NO = iad_pkg::IAD_ROUTE_NONE;
  localparam iad_pkg::iad_route_t IN = iad_pkg::IAD_ROUTE_INTERNAL;
  localparam iad_pkg::iad_route_t IS = iad_pkg::IAD_ROUTE_ISA;
  localparam iad_pkg::iad_route_t UP = iad_pkg::IAD_ROUTE_UPSTREAM;
  localparam int CYC = iad_pkg::ISA_DIV * iad_pkg::ISA_DEFAULT_CLKS;
  logic clk, resetn, acc_valid, acc_from_isa, acc_is_io, acc_write, pci_claimed;
  logic disk_decode_en, video_fwd_en, fw_write_protect, hole_en, slave_present;
  logic [8:0] hits;
  logic [7:0] pbcs, mml, float_val, isa_data_pins, dflt_rdata;
  logic [31:0] acc_addr, hole_base, hole_limit;
  logic isa_claimed, rom_n, write_blocked, dflt_busy, dflt_done;
  iad_pkg::iad_route_t route;
  int failures = 0;
  int num_checks = 0;

  iad_decoder iad_decoder_i (.clk(clk), .resetn(resetn), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_from_isa(acc_from_isa), .acc_is_io(acc_is_io),
    .acc_write(acc_write), .pci_claimed(pci_claimed), .hit_cfg(hits[0]),
    .hit_pm(hits[1]), .hit_ide_bm(hits[2]), .hit_legacy(hits[3]),
    .hit_dma_regs(hits[4]), .hit_disk(hits[5]), .hit_pbus(hits[6]),
    .hit_event(hits[7]), .hit_intc_win(hits[8]),
    .peripheral_bus_chip_select_control(pbcs), .main_memory_limit(mml),
    .disk_decode_en(disk_decode_en), .video_fwd_en(video_fwd_en),
    .fw_write_protect(fw_write_protect), .hole_en(hole_en), .hole_base(hole_base),
    .hole_limit(hole_limit), .isa_claimed(isa_claimed), .isa_data_pins(isa_data_pins),
    .route(route), .firmware_rom_select_n(rom_n), .write_blocked(write_blocked),
    .dflt_busy(dflt_busy), .dflt_done(dflt_done), .dflt_rdata(dflt_rdata));

  iad_isa_bus_model iad_isa_bus_model_i (.clk(clk), .resetn(resetn),
    .acc_valid(acc_valid), .acc_from_isa(acc_from_isa), .route(route),
    .dflt_busy(dflt_busy), .slave_present(slave_present), .float_val(float_val),
    .isa_claimed(isa_claimed), .isa_data_pins(isa_data_pins));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic fail(input string what);
    failures++;
    $display("[ERR] %0t %s", $time, what);
  endtask
  task automatic cmp_route(input iad_pkg::iad_route_t got, input iad_pkg::iad_route_t exp);
    num_checks++;
    if (got !== exp) fail($sformatf("route %0d expected %0d addr %h", got, exp, acc_addr));
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) fail($sformatf("flag %b expected %b addr %h", got, exp, acc_addr));
  endtask
  task automatic cmp_num(input int got, input int exp);
    num_checks++;
    if (got != exp) fail($sformatf("count %0d expected %0d", got, exp));
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("data %h expected %h", got, exp));
  endtask

  // Present an access just after an edge, let the decode settle
  task automatic put(input logic [31:0] a, input logic isa, input logic [7:0] pb,
                     input logic [7:0] ml);
    @(posedge clk);
    #1;
    acc_addr = a;
    acc_from_isa = isa;
    pbcs = pb;
    mml = ml;
    #1;
  endtask
  task automatic dec(input logic [31:0] a, input logic isa, input logic [7:0] pb,
                     input logic [7:0] ml, input iad_pkg::iad_route_t er, input logic ern);
    put(a, isa, pb, ml);
    cmp_route(route, er);
    cmp_bit(rom_n, ern);
  endtask

  // One unclaimed PCI cycle onto ISA, timed from its start edge
  task automatic dflt(input logic wr, input logic [7:0] v);
    int k;
    int seen;
    @(posedge clk);
    #1;
    float_val = v;
    acc_write = wr;
    acc_valid = 1'b1;
    @(posedge clk);
    #1;
    acc_valid = 1'b0;
    k = 1;
    seen = (dflt_busy === 1'b1);
    while (dflt_done !== 1'b1 && k < 300) begin
      @(posedge clk);
      #1;
      k++;
      seen += (dflt_busy === 1'b1);
    end
    cmp_num(k, CYC + 1);
    cmp_num(seen, CYC);
    if (!wr) cmp_byte(dflt_rdata, v);
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    fail("timeout");
    test_done();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    // Access held valid with a slave answering, so map tests start no default cycle
    {acc_valid, acc_from_isa, acc_is_io, acc_write, pci_claimed} = 5'h10;
    {disk_decode_en, video_fwd_en, fw_write_protect, hole_en, slave_present} = 5'h01;
    hits = 9'h000;
    pbcs = iad_pkg::PBCS_RESET;
    mml = iad_pkg::MML_RESET;
    float_val = 8'h00;
    acc_addr = 32'h0000_0000;
    hole_base = 32'h0010_0000;
    hole_limit = 32'h0011_0000;
    repeat (10) @(posedge clk);
    #1;
    resetn = 1'b1;
    // PCI side memory map and firmware selects
    dec(32'h0000_1000, 1'b0, 8'h00, 8'h02, IS, 1'b1);
    dec(32'h00ff_ffff, 1'b0, 8'h00, 8'h02, IS, 1'b1);
    dec(32'h0100_0000, 1'b0, 8'h00, 8'h02, NO, 1'b1);
    dec(32'h000f_0000, 1'b0, 8'h00, 8'h02, IS, 1'b0);
    dec(32'h000e_0000, 1'b0, 8'h00, 8'h02, IS, 1'b1);
    dec(32'h000e_ffff, 1'b0, 8'h40, 8'h02, IS, 1'b0);
    dec(32'hfffe_0000, 1'b0, 8'h40, 8'h02, IS, 1'b0);
    dec(32'hfffe_ffff, 1'b0, 8'h00, 8'h02, NO, 1'b1);
    dec(32'hfff8_0000, 1'b0, 8'h80, 8'h02, IS, 1'b0);
    dec(32'hfffd_ffff, 1'b0, 8'h00, 8'h02, NO, 1'b1);
    pci_claimed = 1'b1;
    dec(32'h0000_1000, 1'b0, 8'h00, 8'h02, NO, 1'b1);
    pci_claimed = 1'b0;
    // ISA and DMA initiated memory map, limit 2 Mbytes
    dec(32'h0007_ffff, 1'b1, 8'h00, 8'h0a, UP, 1'b1);
    dec(32'h0008_0000, 1'b1, 8'h00, 8'h0a, IS, 1'b1);
    dec(32'h0009_ffff, 1'b1, 8'h00, 8'h08, UP, 1'b1);
    dec(32'h000a_0000, 1'b1, 8'h00, 8'h0a, IS, 1'b1);
    dec(32'h000d_0000, 1'b1, 8'h00, 8'h0a, IS, 1'b1);
    dec(32'h000e_0000, 1'b1, 8'h00, 8'h0a, UP, 1'b1);
    dec(32'h000e_0000, 1'b1, 8'h40, 8'h0a, IS, 1'b0);
    dec(32'h000e_0000, 1'b1, 8'h00, 8'h02, IS, 1'b1);
    dec(32'h000f_0000, 1'b1, 8'h00, 8'h0a, IS, 1'b0);
    dec(32'h0010_0000, 1'b1, 8'h00, 8'h0a, UP, 1'b1);
    dec(32'h001f_ffff, 1'b1, 8'h00, 8'h0a, UP, 1'b1);
    dec(32'h0020_0000, 1'b1, 8'h00, 8'h0a, IS, 1'b1);
    dec(32'h07ff_ffff, 1'b1, 8'h00, 8'h0a, IS, 1'b1);
    hole_en = 1'b1;
    put(32'h0010_8000, 1'b1, 8'h00, 8'h0a);
    cmp_route(route, IS);
    video_fwd_en = 1'b1;
    dec(32'h000b_ffff, 1'b1, 8'h00, 8'h0a, UP, 1'b1);
    $display("memory map test done");
    // Internal register claims
    acc_is_io = 1'b1;
    put(32'h0000_0080, 1'b1, 8'h00, 8'h0a);
    cmp_route(route, IS);
    hits = 9'h001;
    put(32'h0000_0cf8, 1'b0, 8'h00, 8'h0a);
    cmp_route(route, IN);
    put(32'h0000_0cf8, 1'b1, 8'h00, 8'h0a);
    cmp_route(route, IS);
    hits = 9'h008;
    put(32'h0000_0020, 1'b1, 8'h00, 8'h0a);
    cmp_route(route, IN);
    hits = 9'h010;
    put(32'h0000_0000, 1'b0, 8'h00, 8'h0a);
    cmp_route(route, IN);
    pci_claimed = 1'b1;
    put(32'h0000_0000, 1'b0, 8'h00, 8'h0a);
    cmp_route(route, NO);
    pci_claimed = 1'b0;
    hits = 9'h040;
    put(32'h0000_0070, 1'b0, 8'h00, 8'h0a);
    cmp_route(route, IN);
    hits = 9'h020;
    disk_decode_en = 1'b1;
    put(32'h0000_01f0, 1'b0, 8'h00, 8'h0a);
    cmp_route(route, IN);
    disk_decode_en = 1'b0;
    put(32'h0000_01f0, 1'b0, 8'h00, 8'h0a);
    cmp_route(route, NO);
    acc_is_io = 1'b0;
    hits = 9'h100;
    put(32'hfec0_0000, 1'b0, 8'h00, 8'h0a);
    cmp_route(route, IN);
    put(32'hfec0_0000, 1'b1, 8'h00, 8'h0a);
    cmp_route(route, IS);
    hits = 9'h000;
    $display("claim test done");
    // Firmware write protection
    acc_write = 1'b1;
    fw_write_protect = 1'b1;
    put(32'hfff8_0000, 1'b0, 8'h80, 8'h02);
    cmp_bit(write_blocked, 1'b1);
    put(32'h000e_0000, 1'b0, 8'h40, 8'h02);
    cmp_bit(write_blocked, 1'b1);
    put(32'h0000_1000, 1'b0, 8'h00, 8'h02);
    cmp_bit(write_blocked, 1'b0);
    fw_write_protect = 1'b0;
    put(32'hfff8_0000, 1'b0, 8'h80, 8'h02);
    cmp_bit(write_blocked, 1'b0);
    $display("protect test done");
    // Default cycles with no ISA slave, then with one
    {acc_valid, slave_present} = 2'b00;
    put(32'h0000_1000, 1'b0, 8'h00, 8'h02);
    dflt(1'b1, 8'h00);
    dflt(1'b0, 8'ha5);
    dflt(1'b0, 8'h3c);
    slave_present = 1'b1;
    @(posedge clk);
    #1;
    acc_valid = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    cmp_bit(dflt_busy, 1'b0);
    acc_valid = 1'b0;
    $display("default cycle test done");
    test_done();
  end
endmodule
